// *** src/pid_pkg.sv ***
// Overview of operation
// - Filter time in 1 ms steps, 0 to 60; default register write takes 0 to 63 unchecked
// - Image follows input stable for filter time
// - Command high: refresh each cycle, operand time
// - Command low: default register time used
// - Default filter register resets to 10 ms
// - Default register write retimes inputs 0-17
// - Refresh covers 0-17, sixteen-point only 0-7
// - Zero time gives 5/50/200 us minimums
// - Sixteen-point inputs 10-17 fixed 10 ms
// - Interrupt, counter, speed inputs auto-filtered
// - Other inputs keep operand or default register time
package pid_pkg;
    // Clock and tick timing
    localparam int unsigned CLK_PERIOD_NS = 10;        // 100 MHz reference clock
    localparam int unsigned TICK_US_NS    = 1000;      // Fine tick period, 1 us
    localparam int unsigned US_CYCLES     = (TICK_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_MS_US    = 1000;      // Coarse tick, 1 ms in fine ticks
    // Filter figures
    localparam logic [15:0] FILT_MAX_MS     = 16'h003c; // 60 ms ceiling
    localparam logic [15:0] FILT_DEFAULT_MS = 16'h000a; // Default register reset value
    localparam logic [15:0] FILT_FIXED_MS   = 16'h000a; // Fixed upper bank, small variant
    localparam logic [15:0] MIN_FAST_US     = 16'h0005; // Inputs 0..5 at zero setting
    localparam logic [15:0] MIN_MID_US      = 16'h0032; // Inputs 6..7 at zero setting
    localparam logic [15:0] MIN_SLOW_US     = 16'h00c8; // Inputs 8..15 at zero setting
    localparam int unsigned N_IN            = 16;       // Filtered inputs, octal 0..17
    localparam int unsigned N_LOW           = 8;        // Inputs covered on small variant
    localparam int unsigned N_FAST          = 6;        // Inputs with fastest minimum
    // Register map, word index on the register port
    localparam logic [3:0]  OFS_DEFAULT_TIME = 4'h0;   // RW default filter time
    localparam logic [3:0]  OFS_IMAGE        = 4'h1;   // RO input image
    localparam logic [3:0]  OFS_ACTIVE_TIME  = 4'h2;   // RO filter time in use
    localparam logic [3:0]  OFS_STATUS       = 4'h3;   // RO status flags
    localparam int unsigned ST_INVALID_BIT   = 0;      // Last operand was out of range
    localparam int unsigned ST_SIXTEEN_BIT   = 1;      // Small variant selected
endpackage

// *** src/pid_tick_if.sv ***
`timescale 1ns/1ps
// Shared time base between tick generator and filter channels
interface pid_tick_if;
    logic tick_us;   // One-cycle pulse every microsecond
    logic tick_ms;   // One-cycle pulse every millisecond
    modport src (output tick_us, output tick_ms);
    modport snk (input tick_us, input tick_ms);
endinterface

// *** src/pid_tick_gen.sv ***
`timescale 1ns/1ps
module pid_tick_gen (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    pid_tick_if.src   tick
);
    typedef struct packed {
        logic [6:0] us_cnt;   // Cycles inside one microsecond
        logic [9:0] ms_cnt;   // Microseconds inside one millisecond
        logic       tick_us;  // Fine pulse
        logic       tick_ms;  // Coarse pulse
    } pid_tick_st_t;

    pid_tick_st_t st_reg;
    pid_tick_st_t st_next;

    // Divider chain; ms tick coincides with the us tick that wraps it
    always_comb
    begin
        st_next         = st_reg;
        st_next.tick_us = 1'b0;
        st_next.tick_ms = 1'b0;
        if (st_reg.us_cnt == 7'(pid_pkg::US_CYCLES - 1))
        begin
            st_next.us_cnt  = 7'h00;
            st_next.tick_us = 1'b1;
            if (st_reg.ms_cnt == 10'(pid_pkg::TICK_MS_US - 1))
            begin
                st_next.ms_cnt  = 10'h000;
                st_next.tick_ms = 1'b1;
            end
            else
            begin
                st_next.ms_cnt = st_reg.ms_cnt + 10'h001;
            end
        end
        else
        begin
            st_next.us_cnt = st_reg.us_cnt + 7'h01;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick.tick_us = st_reg.tick_us;
    assign tick.tick_ms = st_reg.tick_ms;

    // Fine ticks never closer than nine cycles of the reference clock
    a_us_spacing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_reg.tick_us |=> !st_reg.tick_us [*8]) else $error("us tick too close");
endmodule

// *** src/pid_chan.sv ***
`timescale 1ns/1ps
module pid_chan (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    pid_tick_if.snk          tick,
    input  wire logic        sample_i,   // Synchronised raw input
    input  wire logic        use_us_i,   // Count microseconds instead of ms
    input  wire logic [15:0] limit_i,    // Ticks of stability required
    output logic             level_o     // Debounced level
);
    typedef struct packed {
        logic        level;  // Accepted level
        logic        last;   // Sample seen last cycle
        logic [15:0] cnt;    // Stable ticks so far
    } pid_chan_st_t;

    pid_chan_st_t st_reg;
    pid_chan_st_t st_next;
    logic         tick_sel;  // Tick matching current mode

    // Debounce: a change restarts the count, stability accepts it
    always_comb
    begin
        st_next  = st_reg;
        tick_sel = use_us_i ? tick.tick_us : tick.tick_ms;
        st_next.last = sample_i;
        if (sample_i != st_reg.last)
        begin
            st_next.cnt = 16'h0000;
        end
        else if (sample_i != st_reg.level)
        begin
            // Limit may drop while counting; compare with >= to avoid sticking
            if (st_reg.cnt >= limit_i)
            begin
                st_next.level = sample_i;
                st_next.cnt   = 16'h0000;
            end
            else if (tick_sel)
            begin
                st_next.cnt = st_reg.cnt + 16'h0001;
            end
        end
        else
        begin
            st_next.cnt = 16'h0000;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level_o = st_reg.level;

    // Level moves only after the sample has held for the limit
    a_level_stable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.level != $past(st_reg.level)) |->
        ($past(st_reg.cnt) >= $past(limit_i))) else $error("level moved early");
endmodule

// *** src/pid_debounce_top.sv ***
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pid_debounce_top (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] raw_in_i,                 // Input terminals, asynchronous
    input  wire logic        scan_end_i,               // End-of-scan pulse from sequencer
    input  wire logic        filtered_refresh_cmd_i,   // Refresh command level
    input  wire logic [15:0] filter_time_op_i,         // Operand filter time in ms
    input  wire logic        sixteen_point_i,          // Small variant select
    input  wire logic [15:0] auto_filter_mask_i,       // Interrupt, counter, speed inputs
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    output logic      [15:0] image_o,                  // Input image memory
    output logic             execution_state_out_o,    // Pulse per executed refresh
    output logic             op_invalid_o              // Operand out of range
);
    typedef struct packed {
        logic [15:0] sync1;        // First synchroniser stage
        logic [15:0] sync2;        // Second synchroniser stage
        logic [15:0] dft;          // Default filter time register
        logic [15:0] active;       // Filter time in use
        logic [15:0] image;        // Input image memory
        logic [15:0] rdata;        // Read data, valid one cycle after strobe
        logic        exec;         // Refresh executed
        logic        invalid;      // Operand rejected
        logic        sixteen;      // Variant sampled
    } pid_top_st_t;

    pid_top_st_t st_reg;
    pid_top_st_t st_next;
    logic [15:0] filt;             // Debounced levels
    logic [15:0] lim [pid_pkg::N_IN];  // Per-input limits
    logic [15:0] use_us;           // Per-input fine-tick mode
    logic        op_ok;            // Operand in range
    logic        refresh;          // Refresh fires this cycle

    pid_tick_if tick_bus ();

    pid_tick_gen u_tick (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick      (tick_bus.src)
    );

    // Per-input filter setting and channel
    generate
        for (genvar i = 0; i < pid_pkg::N_IN; i++)
        begin : g_chan
            // Limit selection; priorities fixed bank, override, zero, programmed
            always_comb
            begin
                if (st_reg.sixteen && (i >= pid_pkg::N_LOW))
                begin
                    use_us[i] = 1'b0;
                    lim[i]    = pid_pkg::FILT_FIXED_MS;
                end
                else if (auto_filter_mask_i[i] || (st_reg.active == 16'h0000))
                begin
                    use_us[i] = 1'b1;
                    if (i < pid_pkg::N_FAST)
                        lim[i] = pid_pkg::MIN_FAST_US;
                    else if (i < pid_pkg::N_LOW)
                        lim[i] = pid_pkg::MIN_MID_US;
                    else
                        lim[i] = pid_pkg::MIN_SLOW_US;
                end
                else
                begin
                    use_us[i] = 1'b0;
                    lim[i]    = st_reg.active;
                end
            end

            pid_chan u_chan (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .tick      (tick_bus.snk),
                .sample_i  (st_reg.sync2[i]),
                .use_us_i  (use_us[i]),
                .limit_i   (lim[i]),
                .level_o   (filt[i])
            );
        end
    endgenerate

    // Control, image update and register port
    always_comb
    begin
        st_next         = st_reg;
        st_next.sync1   = raw_in_i;
        st_next.sync2   = st_reg.sync1;
        st_next.sixteen = sixteen_point_i;
        st_next.exec    = 1'b0;
        op_ok   = (filter_time_op_i <= pid_pkg::FILT_MAX_MS);
        refresh = filtered_refresh_cmd_i && scan_end_i && op_ok;
        // Time source: operand while commanded, default register otherwise
        if (filtered_refresh_cmd_i)
        begin
            if (op_ok)
                st_next.active = filter_time_op_i;
            st_next.invalid = !op_ok;
        end
        else
        begin
            st_next.active  = st_reg.dft;
            st_next.invalid = 1'b0;
        end
        // Image refreshed once per operation cycle from debounced levels
        if (scan_end_i)
            st_next.image = filt;
        if (refresh)
            st_next.exec = 1'b1;
        // Software write; only the time field is kept, clipped to six bits
        if (reg_wr_i && (reg_addr_i == pid_pkg::OFS_DEFAULT_TIME))
            st_next.dft = {10'h000, reg_wdata_i[5:0]};
        // Read data, zero for unmapped addresses
        st_next.rdata = 16'h0000;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                pid_pkg::OFS_DEFAULT_TIME: st_next.rdata = st_reg.dft;
                pid_pkg::OFS_IMAGE:        st_next.rdata = st_reg.image;
                pid_pkg::OFS_ACTIVE_TIME:  st_next.rdata = st_reg.active;
                pid_pkg::OFS_STATUS:
                begin
                    st_next.rdata[pid_pkg::ST_INVALID_BIT] = st_reg.invalid;
                    st_next.rdata[pid_pkg::ST_SIXTEEN_BIT] = st_reg.sixteen;
                end
                default:                   st_next.rdata = 16'h0000;
            endcase
        end
    end

    // State register; default time comes up at its documented value
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg        <= '0;
            st_reg.dft    <= pid_pkg::FILT_DEFAULT_MS;
            st_reg.active <= pid_pkg::FILT_DEFAULT_MS;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state record, no logic after the flops
    assign reg_rdata_o           = st_reg.rdata;
    assign image_o               = st_reg.image;
    assign execution_state_out_o = st_reg.exec;
    assign op_invalid_o          = st_reg.invalid;

    // Default register holds its reset value until written
    a_default_reset: assert property (@(posedge ref_clk_i)
        $fell(rst_i) |-> (st_reg.dft == pid_pkg::FILT_DEFAULT_MS))
        else $error("default time not 10 ms");

    // A write to the default time lands on the next edge
    a_default_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == pid_pkg::OFS_DEFAULT_TIME) |=>
        (st_reg.dft[5:0] == $past(reg_wdata_i[5:0]))) else $error("write lost");

    // Command low for two cycles: default register drives the time
    a_idle_uses_dft: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !filtered_refresh_cmd_i ##1 !filtered_refresh_cmd_i |->
        (st_reg.active == $past(st_reg.dft))) else $error("default not applied");

    // Command high with a good operand: operand drives the time
    a_cmd_uses_op: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (filtered_refresh_cmd_i && op_ok) |=>
        (st_reg.active == $past(filter_time_op_i))) else $error("operand not applied");

    // Execution pulse only after a refresh
    a_exec_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        execution_state_out_o |-> $past(refresh)) else $error("spurious execution");

    // Out-of-range operand is flagged and not executed
    a_op_invalid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (filtered_refresh_cmd_i && filter_time_op_i > pid_pkg::FILT_MAX_MS) |=>
        (op_invalid_o && !execution_state_out_o)) else $error("bad operand taken");

    // Scan end copies the debounced levels
    a_image_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        scan_end_i |=> (image_o == $past(filt))) else $error("image not refreshed");

    // Image frozen between scan ends
    a_image_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !scan_end_i |=> $stable(image_o)) else $error("image moved mid-scan");

    // Small variant: upper bank pinned to its fixed time
    a_fixed_bank: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_reg.sixteen |-> (lim[8] == pid_pkg::FILT_FIXED_MS && !use_us[15]))
        else $error("upper bank not fixed");

    // Override input takes its fine-tick minimum
    a_override_min: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (auto_filter_mask_i[0] && !st_reg.sixteen) |->
        (use_us[0] && lim[0] == pid_pkg::MIN_FAST_US)) else $error("override missing");

    // Zero setting: middle and slow minimums
    a_zero_min: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.active == 16'h0000 && !st_reg.sixteen) |->
        (lim[6] == pid_pkg::MIN_MID_US && lim[9] == pid_pkg::MIN_SLOW_US))
        else $error("zero minimum wrong");

    // Upper write bits are never stored, so the time stays six bits wide
    a_write_clip: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == pid_pkg::OFS_DEFAULT_TIME) |=>
        (st_reg.dft[15:6] == 10'h000)) else $error("upper time bits kept");

    // Writes to read-only places leave the default time alone
    a_ro_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i != pid_pkg::OFS_DEFAULT_TIME) |=>
        $stable(st_reg.dft)) else $error("read-only write took effect");

    // Without a write the default time never drifts
    a_dft_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !reg_wr_i |=>
        $stable(st_reg.dft)) else $error("default time drifted");

    // Default time reads back one cycle after the strobe
    a_read_dft: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == pid_pkg::OFS_DEFAULT_TIME) |=>
        (reg_rdata_o == $past(st_reg.dft))) else $error("default read wrong");

    // Image reads back as the image output
    a_read_image: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == pid_pkg::OFS_IMAGE) |=>
        (reg_rdata_o == $past(image_o))) else $error("image read wrong");

    // Active time reads back as the time in use
    a_read_active: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == pid_pkg::OFS_ACTIVE_TIME) |=>
        (reg_rdata_o == $past(st_reg.active))) else $error("active read wrong");

    // Status invalid bit mirrors the operand check
    a_status_invalid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == pid_pkg::OFS_STATUS) |=>
        (reg_rdata_o[pid_pkg::ST_INVALID_BIT] == $past(st_reg.invalid)))
        else $error("status invalid bit wrong");

    // Status variant bit mirrors the sampled select
    a_status_variant: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == pid_pkg::OFS_STATUS) |=>
        (reg_rdata_o[pid_pkg::ST_SIXTEEN_BIT] == $past(st_reg.sixteen)))
        else $error("status variant bit wrong");

    // Read data stand one cycle only, so a stale word is never mistaken
    a_read_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !reg_rd_i |=>
        (reg_rdata_o == 16'h0000)) else $error("read data left standing");

    // Every refresh is reported
    a_exec_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        refresh |=>
        execution_state_out_o) else $error("refresh not reported");

    // Execution belongs to a scan end
    a_exec_scan: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        execution_state_out_o |->
        $past(scan_end_i)) else $error("execution without scan end");

    // Command low: no execution and no invalid flag
    a_cmd_off_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !filtered_refresh_cmd_i |=>
        (!execution_state_out_o && !op_invalid_o)) else $error("idle command active");

    // Good operand never flagged
    a_valid_op: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (filtered_refresh_cmd_i && op_ok) |=>
        !op_invalid_o) else $error("good operand flagged");

    // Bad operand keeps the previous time
    a_bad_keeps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (filtered_refresh_cmd_i && !op_ok) |=>
        $stable(st_reg.active)) else $error("bad operand changed time");

    // Zero setting: fastest inputs on the shortest minimum
    a_zero_fast: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.active == 16'h0000) |->
        (use_us[0] && lim[0] == pid_pkg::MIN_FAST_US)) else $error("fast minimum wrong");

    // Small variant still filters the lower bank
    a_small_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.sixteen && st_reg.active == 16'h0000) |->
        (use_us[7] && lim[7] == pid_pkg::MIN_MID_US)) else $error("lower bank not filtered");

    // Plain inputs follow the time in use
    a_prog_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.active != 16'h0000 && !st_reg.sixteen && !auto_filter_mask_i[9]) |->
        (!use_us[9] && lim[9] == st_reg.active)) else $error("programmed time not used");

    // Fixed upper bank counts whole milliseconds
    a_upper_ms: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_reg.sixteen |->
        (lim[15] == pid_pkg::FILT_FIXED_MS && !use_us[8])) else $error("upper bank fine");

    // Second stage only ever copies the first
    a_sync_chain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_reg.sync2 == $past(st_reg.sync1))
        else $error("synchroniser skipped");
endmodule

// *** dv/pid_contacts.sv ***
`timescale 1ns/1ps
// Switch contacts on the input terminals, with a short chatter on every change
module pid_contacts (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] level_i,     // Level the contacts settle to
    output logic      [15:0] contact_o    // Terminal levels seen by the block
);
    logic [15:0] last_reg = 16'h0000;     // Last commanded level
    logic [15:0] chg_reg  = 16'h0000;     // Bits that are still chattering
    logic [3:0]  bounce_reg = 4'h0;       // Chatter cycles left
    // Chatter toggles only the changed bits, so a filter must restart its count
    always_ff @(posedge ref_clk_i)
    begin
        if (level_i != last_reg)
        begin
            last_reg   <= level_i;
            chg_reg    <= level_i ^ last_reg;
            bounce_reg <= 4'h8;
        end
        else if (bounce_reg != 4'h0)
        begin
            bounce_reg <= bounce_reg - 4'h1;
        end
        // Odd chatter cycles show the old level again
        contact_o <= (bounce_reg[0]) ? (level_i ^ chg_reg) : level_i;
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// One comparison, counted; mismatch reported at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [15:0] level     = 16'h0000;  // Commanded contact levels
    logic [15:0] raw_in;                // Terminals from the contacts
    logic        scan_end  = 1'b0;
    logic        cmd       = 1'b0;
    logic [15:0] op        = 16'h0000;
    logic        sixteen   = 1'b0;
    logic [15:0] mask      = 16'h0000;
    logic [3:0]  addr      = 4'h0;
    logic [15:0] wdata     = 16'h0000;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [15:0] rdata;
    logic [15:0] image;
    logic        exec;
    logic        invalid;
    logic [15:0] got;
    int          failures  = 0;
    int          checked   = 0;

    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    pid_contacts i_contacts (
        .ref_clk_i (ref_clk_i),
        .level_i   (level),
        .contact_o (raw_in)
    );

    pid_debounce_top i_dut (
        .ref_clk_i              (ref_clk_i),
        .rst_i                  (rst_i),
        .raw_in_i               (raw_in),
        .scan_end_i             (scan_end),
        .filtered_refresh_cmd_i (cmd),
        .filter_time_op_i       (op),
        .sixteen_point_i        (sixteen),
        .auto_filter_mask_i     (mask),
        .reg_addr_i             (addr),
        .reg_wdata_i            (wdata),
        .reg_wr_i               (wr),
        .reg_rd_i               (rd),
        .reg_rdata_o            (rdata),
        .image_o                (image),
        .execution_state_out_o  (exec),
        .op_invalid_o           (invalid)
    );

    // Verdict and end of run, reached from the main sequence or the watchdog
    task automatic conclude();
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd   <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata;
        @(posedge ref_clk_i);
    endtask

    // End-of-scan pulse; image and execution pulse land one cycle later
    task automatic scan(input logic [15:0] exp_img, input logic exp_exec);
        @(posedge ref_clk_i);
        scan_end <= 1'b1;
        @(posedge ref_clk_i);
        scan_end <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(image, exp_img)
        `CHK(exec, exp_exec)
        @(posedge ref_clk_i);
    endtask

    // Fixed waits in microseconds of the reference clock
    task automatic wait_us(input int n);
        repeat (n * 100) @(posedge ref_clk_i);
    endtask

    // Watchdog: every wait above is bounded, this caps the whole run
    initial
    begin
        #900_000;
        failures++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // Reset values of the register map
        reg_read(pid_pkg::OFS_DEFAULT_TIME, got);
        `CHK(got, pid_pkg::FILT_DEFAULT_MS)
        reg_read(pid_pkg::OFS_ACTIVE_TIME, got);
        `CHK(got, 16'h000a)
        reg_read(pid_pkg::OFS_STATUS, got);
        `CHK(got, 16'h0000)
        // Only six bits stored; read-only write ignored, unmapped place reads zero
        reg_write(pid_pkg::OFS_DEFAULT_TIME, 16'h00ff);
        reg_write(pid_pkg::OFS_IMAGE, 16'h1234);
        reg_read(pid_pkg::OFS_DEFAULT_TIME, got);
        `CHK(got, 16'h003f)
        reg_read(pid_pkg::OFS_IMAGE, got);
        `CHK(got, 16'h0000)
        reg_read(4'h7, got);
        `CHK(got, 16'h0000)
        reg_write(pid_pkg::OFS_DEFAULT_TIME, 16'h000a);
        reg_read(pid_pkg::OFS_ACTIVE_TIME, got);
        `CHK(got, 16'h000a)
        // Override input 0 only: fast minimum, input 1 keeps 10 ms
        mask  <= 16'h0001;
        level <= 16'h0003;
        wait_us(30);
        scan(16'h0001, 1'b0);
        level <= 16'h0000;
        wait_us(30);
        scan(16'h0000, 1'b0);
        mask  <= 16'h0000;
        // Operand above 60: refused, no execution pulse, time kept
        cmd <= 1'b1;
        op  <= 16'h003d;
        wait_us(1);
        @(negedge ref_clk_i);
        `CHK(invalid, 1'b1)
        @(posedge ref_clk_i);
        reg_read(pid_pkg::OFS_STATUS, got);
        `CHK(got, 16'h0001)
        scan(16'h0000, 1'b0);
        reg_read(pid_pkg::OFS_ACTIVE_TIME, got);
        `CHK(got, 16'h000a)
        // Operand zero: refresh runs and minimum filters apply
        op <= 16'h0000;
        wait_us(1);
        @(negedge ref_clk_i);
        `CHK(invalid, 1'b0)
        @(posedge ref_clk_i);
        reg_read(pid_pkg::OFS_ACTIVE_TIME, got);
        `CHK(got, 16'h0000)
        // A pulse shorter than the minimum never reaches the image
        level <= 16'h0001;
        wait_us(2);
        level <= 16'h0000;
        wait_us(20);
        scan(16'h0000, 1'b1);
        // Rising edge on all inputs, staged by the three minimums
        level <= 16'hffff;
        wait_us(30);
        scan(16'h003f, 1'b1);
        wait_us(15);
        scan(16'h003f, 1'b1);
        wait_us(15);
        scan(16'h00ff, 1'b1);
        wait_us(130);
        scan(16'h00ff, 1'b1);
        wait_us(25);
        scan(16'hffff, 1'b1);
        // Small variant: upper bank held by its fixed 10 ms filter
        sixteen <= 1'b1;
        level   <= 16'h0000;
        wait_us(100);
        scan(16'hff00, 1'b1);
        reg_read(pid_pkg::OFS_STATUS, got);
        `CHK(got, 16'h0002)
        conclude();
    end
endmodule
